// File: hdl/pao_oscillator.sv
/*
  Numerically controlled oscillator with AXI4-Lite register slave.
  Assumes source clock levels arrive synchronous to mclk and slower than mclk/2.
*/
// Function
// - 20-bit accumulator readable and writable through low, high, upper bytes.
// - Each source clock rising edge, accumulator becomes accumulator plus buffered increment.
// - Carry out of the addition is the raw overflow event.
// - Increment is 20 bits over low, high, upper byte registers, read/write.
// - Enabled: low increment write loads buffer on second source edge after.
// - Disabled: buffer loads right after any increment write; buffer is hidden.
// - Pulse select clear: output toggles on every overflow.
// - Pulse select set: output active after overflow for 1 to 128 periods.
// - Pulse wider than overflow interval leaves output without toggling.
// - Polarity bit is last stage; set inverts the output.
// - Polarity change with interrupts enabled raises the interrupt.
// - Overflow sets flag; request needs enable, flag enable, outer enables.
// - Any reset clears all oscillator registers to zero.
// - Keeps running in Sleep while the selected source runs.
// - Enabled with internal high frequency source keeps that oscillator running.
// - Source clock chosen by a multiplexer steered by the select field.
// - Overflow jitter at most one source period, none for exact division.
// - Width code is a power of two, 000 one period, 111 128.
// - Runs only while module enable is set.
// - Read-only status bit shows current output level.
`timescale 1ns/100ps
`include "pao_params.svh"

module pao_oscillator
  import pao_pkg::*;
#(
  parameter int NUM_SRC = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [NUM_SRC-1:0] sourceClocks,
  input wire logic sleepMode,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic oscillatorOutput,
  output logic irqRequest,
  output logic hfOscKeepAlive
);

  // Select code is four bits wide, so at most 16 sources
  if (NUM_SRC < 1 || NUM_SRC > 16) begin : gBadNumSrc
    $error("NUM_SRC must lie in 1..16");
  end

  // Bus state
  logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [13:0] wIdx_reg, wIdx_next;
  logic [7:0] wByte_reg, wByte_next;
  logic wLane_reg, wLane_next;
  logic awReady_reg, awReady_next, wReady_reg, wReady_next;
  logic bValid_reg, bValid_next, arReady_reg, arReady_next, rValid_reg, rValid_next;
  logic [1:0] bResp_reg, bResp_next, rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  // Oscillator state
  logic [`PAO_ACC_W-1:0] acc_reg, acc_next, inc_reg, inc_next, incBuf_reg, incBuf_next;
  logic enable_reg, enable_next, invert_reg, invert_next;
  pao_mode_t mode_reg, mode_next;
  logic [2:0] pws_reg, pws_next;
  logic [3:0] cks_reg, cks_next;
  logic irqFlag_reg, irqFlag_next, irqEn_reg, irqEn_next;
  logic [1:0] loadWait_reg, loadWait_next;
  logic loadNow_reg, loadNow_next;
  logic srcPrev_reg, srcPrev_next, rawOut_reg, rawOut_next;
  logic [`PAO_PW_W-1:0] pwCnt_reg, pwCnt_next;
  logic oscOut_reg, oscOut_next, irqReq_reg, irqReq_next, hfKeep_reg, hfKeep_next;

  logic srcLevel, srcTick, carry, doWrite, hit, rHit;
  logic [`PAO_ACC_W-1:0] sum;
  logic [`PAO_PW_W-1:0] widthM1;
  logic [7:0] rByte;
  logic [13:0] rIdx;

  always_comb begin
    srcLevel = (32'(cks_reg) < NUM_SRC) ? sourceClocks[cks_reg] : 1'b0;
    srcTick = srcLevel & ~srcPrev_reg & enable_reg;
    {carry, sum} = {1'b0, acc_reg} + {1'b0, incBuf_reg};
    widthM1 = `PAO_PW_W'((8'h01 << pws_reg) - 8'h01);
    doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
    rIdx = s_axi_araddr[15:2];
    // Defaults
    awHeld_next = awHeld_reg | (s_axi_awvalid & awReady_reg);
    wHeld_next = wHeld_reg | (s_axi_wvalid & wReady_reg);
    wIdx_next = (s_axi_awvalid & awReady_reg) ? s_axi_awaddr[15:2] : wIdx_reg;
    wByte_next = (s_axi_wvalid & wReady_reg) ? s_axi_wdata[7:0] : wByte_reg;
    wLane_next = (s_axi_wvalid & wReady_reg) ? s_axi_wstrb[0] : wLane_reg;
    bValid_next = bValid_reg & ~s_axi_bready;
    bResp_next = bResp_reg;
    acc_next = acc_reg;
    inc_next = inc_reg;
    incBuf_next = incBuf_reg;
    enable_next = enable_reg;
    invert_next = invert_reg;
    mode_next = mode_reg;
    pws_next = pws_reg;
    cks_next = cks_reg;
    irqEn_next = irqEn_reg;
    irqFlag_next = irqFlag_reg;
    loadWait_next = loadWait_reg;
    loadNow_next = 1'b0;
    srcPrev_next = srcLevel;
    rawOut_next = rawOut_reg;
    pwCnt_next = pwCnt_reg;
    hit = 1'b1;
    // Register write
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      if (wLane_reg) begin
        case (wIdx_reg)
          `PAO_IDX_ACCL: acc_next[7:0] = wByte_reg;
          `PAO_IDX_ACCH: acc_next[15:8] = wByte_reg;
          `PAO_IDX_ACCU: acc_next[19:16] = wByte_reg[3:0];
          `PAO_IDX_INCL: inc_next[7:0] = wByte_reg;
          `PAO_IDX_INCH: inc_next[15:8] = wByte_reg;
          `PAO_IDX_INCU: inc_next[19:16] = wByte_reg[3:0];
          `PAO_IDX_CTRL: begin
            enable_next = wByte_reg[`PAO_CTRL_EN];
            invert_next = wByte_reg[`PAO_CTRL_INV];
            mode_next = pao_mode_t'(wByte_reg[`PAO_CTRL_PFM]);
          end
          `PAO_IDX_CLKS: begin
            pws_next = wByte_reg[`PAO_CLKS_PWS_LO +: 3];
            cks_next = wByte_reg[`PAO_CLKS_CKS_LO +: 4];
          end
          `PAO_IDX_IRQ: begin
            irqFlag_next = wByte_reg[`PAO_IRQ_FLAG];
            irqEn_next = wByte_reg[`PAO_IRQ_IE];
          end
          default: hit = 1'b0;
        endcase
        if (wIdx_reg == `PAO_IDX_INCL && enable_reg) begin
          loadWait_next = 2'h2;
        end
        if (!enable_reg && (wIdx_reg == `PAO_IDX_INCL || wIdx_reg == `PAO_IDX_INCH ||
            wIdx_reg == `PAO_IDX_INCU)) begin
          loadNow_next = 1'b1;
        end
      end else begin
        hit = (wIdx_reg >= `PAO_IDX_ACCL) && (wIdx_reg <= `PAO_IDX_IRQ);
      end
      bResp_next = hit ? `PAO_RESP_OKAY : `PAO_RESP_SLVERR;
    end
    if (loadNow_reg) begin
      incBuf_next = inc_reg;
    end
    // Second source edge after the low byte write copies all three bytes
    if (srcTick && loadWait_reg != 2'h0) begin
      loadWait_next = loadWait_reg - 2'h1;
      if (loadWait_reg == 2'h1) begin
        incBuf_next = inc_reg;
      end
    end
    if (srcTick) begin
      acc_next = sum;
      if (carry) begin
        irqFlag_next = 1'b1;
      end
      if (mode_reg == PAO_TOGGLE_MODE) begin
        if (carry) begin
          rawOut_next = ~rawOut_reg;
        end
      end else if (carry) begin
        rawOut_next = 1'b1;
        pwCnt_next = widthM1;
      end else if (pwCnt_reg != '0) begin
        pwCnt_next = pwCnt_reg - `PAO_PW_W'(1);
      end else begin
        rawOut_next = 1'b0;
      end
    end
    if (!enable_reg) begin
      rawOut_next = 1'b0;
      pwCnt_next = '0;
      loadWait_next = 2'h0;
    end
    // Polarity change while interrupts enabled
    if (invert_next != invert_reg && irqEn_reg) begin
      irqFlag_next = 1'b1;
    end
    oscOut_next = rawOut_next ^ invert_next;
    irqReq_next = irqFlag_next & irqEn_next & enable_next;
    hfKeep_next = enable_next && (cks_next == `PAO_CKS_HFOSC);
    awReady_next = ~awHeld_next & ~bValid_next;
    wReady_next = ~wHeld_next & ~bValid_next;
    // Read channel
    rValid_next = rValid_reg & ~s_axi_rready;
    rData_next = rData_reg;
    rResp_next = rResp_reg;
    rHit = 1'b1;
    case (rIdx)
      `PAO_IDX_ACCL: rByte = acc_reg[7:0];
      `PAO_IDX_ACCH: rByte = acc_reg[15:8];
      `PAO_IDX_ACCU: rByte = {4'h0, acc_reg[19:16]};
      `PAO_IDX_INCL: rByte = inc_reg[7:0];
      `PAO_IDX_INCH: rByte = inc_reg[15:8];
      `PAO_IDX_INCU: rByte = {4'h0, inc_reg[19:16]};
      `PAO_IDX_CTRL: rByte = {enable_reg, 1'b0, oscOut_reg, invert_reg, 3'h0, mode_reg};
      `PAO_IDX_CLKS: rByte = {pws_reg, 1'b0, cks_reg};
      `PAO_IDX_IRQ: rByte = {6'h00, irqEn_reg, irqFlag_reg};
      default: begin
        rByte = 8'h00;
        rHit = 1'b0;
      end
    endcase
    if (s_axi_arvalid && arReady_reg) begin
      rValid_next = 1'b1;
      rData_next = {24'h000000, rByte};
      rResp_next = rHit ? `PAO_RESP_OKAY : `PAO_RESP_SLVERR;
    end
    arReady_next = ~rValid_next;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      wIdx_reg <= 14'h0000;
      wByte_reg <= `PAO_RST_BYTE;
      wLane_reg <= 1'b0;
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      bValid_reg <= 1'b0;
      bResp_reg <= `PAO_RESP_OKAY;
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rResp_reg <= `PAO_RESP_OKAY;
      rData_reg <= 32'h00000000;
      acc_reg <= `PAO_RST_ACC;
      inc_reg <= `PAO_RST_ACC;
      incBuf_reg <= `PAO_RST_ACC;
      enable_reg <= 1'b0;
      invert_reg <= 1'b0;
      mode_reg <= PAO_TOGGLE_MODE;
      pws_reg <= 3'h0;
      cks_reg <= 4'h0;
      irqFlag_reg <= 1'b0;
      irqEn_reg <= 1'b0;
      loadWait_reg <= 2'h0;
      loadNow_reg <= 1'b0;
      srcPrev_reg <= 1'b0;
      rawOut_reg <= 1'b0;
      pwCnt_reg <= '0;
      oscOut_reg <= 1'b0;
      irqReq_reg <= 1'b0;
      hfKeep_reg <= 1'b0;
    end else begin
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      wIdx_reg <= wIdx_next;
      wByte_reg <= wByte_next;
      wLane_reg <= wLane_next;
      awReady_reg <= awReady_next;
      wReady_reg <= wReady_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      arReady_reg <= arReady_next;
      rValid_reg <= rValid_next;
      rResp_reg <= rResp_next;
      rData_reg <= rData_next;
      acc_reg <= acc_next;
      inc_reg <= inc_next;
      incBuf_reg <= incBuf_next;
      enable_reg <= enable_next;
      invert_reg <= invert_next;
      mode_reg <= mode_next;
      pws_reg <= pws_next;
      cks_reg <= cks_next;
      irqFlag_reg <= irqFlag_next;
      irqEn_reg <= irqEn_next;
      loadWait_reg <= loadWait_next;
      loadNow_reg <= loadNow_next;
      srcPrev_reg <= srcPrev_next;
      rawOut_reg <= rawOut_next;
      pwCnt_reg <= pwCnt_next;
      oscOut_reg <= oscOut_next;
      irqReq_reg <= irqReq_next;
      hfKeep_reg <= hfKeep_next;
    end
  end

  // Sleep does not stop the oscillator; it runs from its source alone
  logic unusedSleep;
  assign unusedSleep = sleepMode;

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign oscillatorOutput = oscOut_reg;
  assign irqRequest = irqReq_reg;
  assign hfOscKeepAlive = hfKeep_reg;

endmodule : pao_oscillator

// File: hdl/pao_params.svh
/*
  Offsets, field positions, reset values and counts of the phase accumulator oscillator.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PAO_PARAMS_SVH
`define PAO_PARAMS_SVH

// Register indices; byte address is four times the index
`define PAO_IDX_ACCL 14'h058C
`define PAO_IDX_ACCH 14'h058D
`define PAO_IDX_ACCU 14'h058E
`define PAO_IDX_INCL 14'h058F
`define PAO_IDX_INCH 14'h0590
`define PAO_IDX_INCU 14'h0591
`define PAO_IDX_CTRL 14'h0592
`define PAO_IDX_CLKS 14'h0593
`define PAO_IDX_IRQ 14'h0594

`define PAO_ACC_W 20
`define PAO_PW_W 7
// osc_control fields
`define PAO_CTRL_EN 7
`define PAO_CTRL_OUT 5
`define PAO_CTRL_INV 4
`define PAO_CTRL_PFM 0
// Clock select register fields
`define PAO_CLKS_PWS_LO 5
`define PAO_CLKS_CKS_LO 0
// Interrupt register fields
`define PAO_IRQ_FLAG 0
`define PAO_IRQ_IE 1
// Source select code of the high frequency internal oscillator
`define PAO_CKS_HFOSC 4'h1
`define PAO_RST_BYTE 8'h00
`define PAO_RST_ACC 20'h00000
`define PAO_RESP_OKAY 2'h0
`define PAO_RESP_SLVERR 2'h2

`endif

// File: hdl/pao_pkg.sv
/*
  Types of the phase accumulator oscillator.
  Assumes nothing of its surroundings.
*/
package pao_pkg;
  typedef enum logic {
    PAO_TOGGLE_MODE = 1'b0,
    PAO_PULSE_MODE = 1'b1
  } pao_mode_t;
endpackage : pao_pkg

// File: testbench/pao_oscillator_properties.sv
/*
  Port assertions of the oscillator and its register bus.
  Assumes binding into pao_oscillator; sees only its ports.
*/
`timescale 1ns/100ps
module pao_oscillator_properties #(
  parameter int NUM_SRC = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [NUM_SRC-1:0] sourceClocks,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic oscillatorOutput,
  input wire logic irqRequest,
  input wire logic hfOscKeepAlive
);
  logic [NUM_SRC-1:0] prevSrc_reg;
  logic [1:0] riseHist_reg;
  logic bvalidD_reg;
  logic srcAct;
  logic wrAct;
  always_ff @(posedge mclk) begin
    prevSrc_reg <= sourceClocks;
    riseHist_reg <= {riseHist_reg[0], |(sourceClocks & ~prevSrc_reg)};
    bvalidD_reg <= s_axi_bvalid;
  end
  // Recent source edge, recent write response
  assign srcAct = (|(sourceClocks & ~prevSrc_reg)) | (|riseHist_reg);
  assign wrAct = s_axi_bvalid | bvalidD_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_quiet_a: assert property (disable iff (1'h0) sys_rst |=>
    !oscillatorOutput && !irqRequest && !hfOscKeepAlive) else $error("outputs not cleared");
  out_cause_a: assert property ($changed(oscillatorOutput) |-> srcAct || wrAct)
    else $error("output moved without cause");
  irq_cause_a: assert property ($rose(irqRequest) |-> srcAct || wrAct)
    else $error("irq rose without cause");
  irq_hold_a: assert property ($fell(irqRequest) |-> wrAct)
    else $error("irq dropped by itself");
  keep_alive_a: assert property ($changed(hfOscKeepAlive) |-> wrAct)
    else $error("keep alive moved without write");
  wr_answer_a: assert property (wrTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (rdTaken |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  rd_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  rd_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
endmodule : pao_oscillator_properties

// File: testbench/pao_peer_model.sv
/*
  Source clock model and observer of the oscillator output.
  Assumes bursts are requested only while the previous one is over.
*/
`timescale 1ns/100ps
module pao_peer_model #(
  parameter int NUM_SRC = 16
) (
  input wire logic mclk,
  input wire logic [3:0] srcSel,
  input wire logic [7:0] burstLen,
  input wire logic burstGo,
  input wire logic oscOut,
  output logic [NUM_SRC-1:0] sourceClocks,
  output int outRises,
  output int outHigh
);
  int halfLeft = 0;
  logic level = 1'h0;
  logic prevOut = 1'h0;
  initial begin
    outRises = 0;
    outHigh = 0;
  end
  // Selected source toggles only in a burst and rests low between
  assign sourceClocks = NUM_SRC'(level) << srcSel;
  always @(posedge mclk) begin
    if (burstGo) halfLeft <= 2 * burstLen;
    else if (halfLeft > 0) begin
      halfLeft <= halfLeft - 1;
      level <= ~level;
    end
    prevOut <= oscOut;
    if (oscOut && !prevOut) outRises <= outRises + 1;
    if (oscOut) outHigh <= outHigh + 1;
  end
endmodule : pao_peer_model

// File: testbench/pao_oscillator_tb.sv
/*
  Register level tests of pao_oscillator over AXI4-Lite.
  Assumes the design files and pao_peer_model are compiled first.
*/
`timescale 1ns/100ps
`include "pao_params.svh"
module pao_oscillator_tb;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic sleepMode = 1'h0;
  logic [15:0] sourceClocks, s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h1, srcSel = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, burstGo = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic oscillatorOutput, irqRequest, hfOscKeepAlive;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] burstLen = 8'h00;
  logic [23:0] sum;
  logic [19:0] incTab [3] = '{20'h30000, 20'h80000, 20'hFFFFF};
  logic [3:0] ckTab [3] = '{4'h2, 4'h1, 4'h3};
  logic [2:0] pwTab [3] = '{3'h0, 3'h1, 3'h7};
  logic [7:0] tkTab [3] = '{8'h06, 8'h06, 8'h0C};
  int errors = 0, cmp_count = 0, cycles = 0, outRises, outHigh, r0, h0;
  pao_oscillator #(.NUM_SRC(16)) u_pao_oscillator (.*);
  pao_peer_model #(.NUM_SRC(16)) u_pao_peer_model (.mclk(mclk), .srcSel(srcSel),
    .burstLen(burstLen), .burstGo(burstGo), .oscOut(oscillatorOutput),
    .sourceClocks(sourceClocks), .outRises(outRises), .outHigh(outHigh));
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axiRd(input logic [13:0] idx, input bit slow = 1'b0);
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= !slow;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      // Late ready: read data must stand until taken
      if (s_axi_rvalid === 1'h1 && !s_axi_rready) s_axi_rready <= 1'h1;
    end while (!(s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1));
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axiRd
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, `PAO_RESP_OKAY);
    s_axi_bready <= 1'h0;
    repeat (2) @(posedge mclk);
  endtask : wr
  task automatic rdChk(input logic [13:0] idx, input logic [7:0] exp, input bit slow = 1'b0);
    axiRd(idx, slow);
    chk(rsp, `PAO_RESP_OKAY);
    chk(rd, {24'h0, exp});
  endtask : rdChk
  task automatic setAcc(input logic [19:0] v);
    wr(`PAO_IDX_ACCL, v[7:0]);
    wr(`PAO_IDX_ACCH, v[15:8]);
    wr(`PAO_IDX_ACCU, {4'h0, v[19:16]});
  endtask : setAcc
  task automatic chkAcc(input logic [19:0] v);
    rdChk(`PAO_IDX_ACCL, v[7:0]);
    rdChk(`PAO_IDX_ACCH, v[15:8]);
    rdChk(`PAO_IDX_ACCU, {4'h0, v[19:16]});
  endtask : chkAcc
  task automatic setInc(input logic [19:0] v);
    wr(`PAO_IDX_INCU, {4'h0, v[19:16]});
    wr(`PAO_IDX_INCH, v[15:8]);
    wr(`PAO_IDX_INCL, v[7:0]);
  endtask : setInc
  task automatic burst(input logic [7:0] n);
    @(posedge mclk);
    burstLen <= n;
    burstGo <= 1'h1;
    @(posedge mclk);
    burstGo <= 1'h0;
    repeat (2 * n + 4) @(posedge mclk);
  endtask : burst
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
    chk(hfOscKeepAlive, 1'h0);
    for (int i = `PAO_IDX_ACCL; i <= `PAO_IDX_IRQ; i++) rdChk(14'(i), 8'h00);
    axiRd(14'h0595, 1'b1);
    chk(rsp, `PAO_RESP_SLVERR);
    chk(rd, 32'h0);
    setInc(20'hABCDE);
    rdChk(`PAO_IDX_INCU, 8'h0A);
    rdChk(`PAO_IDX_INCH, 8'hBC, 1'b1);
    rdChk(`PAO_IDX_INCL, 8'hDE);
    setAcc(20'h12345);
    chkAcc(20'h12345);
    for (int k = 0; k < 3; k++) begin
      wr(`PAO_IDX_CTRL, 8'h00);
      wr(`PAO_IDX_IRQ, 8'h02);
      setAcc(20'h00000);
      setInc(incTab[k]);
      srcSel <= ckTab[k];
      sleepMode <= (k == 1);
      wr(`PAO_IDX_CLKS, {4'h0, ckTab[k]});
      wr(`PAO_IDX_CTRL, 8'h80);
      chk(hfOscKeepAlive, ckTab[k] == `PAO_CKS_HFOSC);
      burst(8'h08);
      sum = {4'h0, incTab[k]} << 3;
      chkAcc(sum[19:0]);
      chk(oscillatorOutput, sum[20]);
      rdChk(`PAO_IDX_CTRL, {2'h2, sum[20], 5'h00});
      rdChk(`PAO_IDX_IRQ, 8'h03);
      chk(irqRequest, 1'h1);
      wr(`PAO_IDX_IRQ, 8'h02);
      chk(irqRequest, 1'h0);
    end
    wr(`PAO_IDX_CTRL, 8'h90);
    chk(oscillatorOutput, 1'h0);
    rdChk(`PAO_IDX_IRQ, 8'h03);
    wr(`PAO_IDX_CTRL, 8'h00);
    burst(8'h04);
    chkAcc(20'hFFFF8);
    srcSel <= 4'h2;
    for (int k = 0; k < 3; k++) begin
      wr(`PAO_IDX_CTRL, 8'h00);
      setAcc(20'h00000);
      setInc(20'h40000);
      wr(`PAO_IDX_CLKS, {pwTab[k], 5'h02});
      wr(`PAO_IDX_CTRL, 8'h81);
      r0 = outRises;
      h0 = outHigh;
      burst(tkTab[k]);
      chk(outRises - r0, 32'h1);
      chk(oscillatorOutput, k == 2);
      if (k < 2) chk(outHigh - h0, 32'h2 << pwTab[k]);
    end
    wr(`PAO_IDX_CTRL, 8'h00);
    setAcc(20'h00000);
    setInc(20'h10000);
    wr(`PAO_IDX_CTRL, 8'h80);
    setInc(20'h20000);
    burst(8'h04);
    chkAcc(20'h60000);
    chk(irqRequest, 1'h1);
    // Reset in mid-run with registers and request set
    @(posedge mclk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    chk(irqRequest, 1'h0);
    for (int i = `PAO_IDX_ACCL; i <= `PAO_IDX_IRQ; i++) rdChk(14'(i), 8'h00);
    complete_run();
  end
endmodule : pao_oscillator_tb
bind pao_oscillator pao_oscillator_properties #(.NUM_SRC(NUM_SRC)) u_pao_oscillator_properties (.*);
